// ### include/dpt_pkg.sv
// constants, encodings and state type of the potentiometer serial slave
package dpt_pkg;

   // =====================================================
   // register geometry
   localparam int unsigned WIPER_W  = 10;
   localparam int unsigned PRESET_N = 4;
   localparam int unsigned SEL_W    = 2;
   localparam logic [9:0]  PRESET_RESET = 10'h200;

   // =====================================================
   // address byte layout
   localparam int unsigned TYPE_HI  = 7;
   localparam int unsigned TYPE_LO  = 4;
   localparam int unsigned PINS_HI  = 3;
   localparam int unsigned PINS_LO  = 1;
   localparam int unsigned DIR_BIT  = 0;

   // =====================================================
   // command byte layout and opcodes
   localparam int unsigned OP_HI    = 7;
   localparam int unsigned OP_LO    = 5;
   localparam int unsigned SEL_HI   = 3;
   localparam int unsigned SEL_LO   = 2;
   localparam logic [2:0]  OP_READ_WIPER    = 3'h4;
   localparam logic [2:0]  OP_WRITE_WIPER   = 3'h5;
   localparam logic [2:0]  OP_READ_PRESET   = 3'h5;
   localparam logic [2:0]  OP_WRITE_PRESET  = 3'h6;
   localparam logic [2:0]  OP_XFR_TO_WIPER  = 3'h6;
   localparam logic [2:0]  OP_XFR_TO_PRESET = 3'h7;

   // =====================================================
   // bit counting
   localparam logic [2:0]  LAST_BIT = 3'h7;

   // =====================================================
   // protocol states
   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0000,
      ST_ADDR     = 4'b0001,
      ST_ADDR_ACK = 4'b0010,
      ST_CMD      = 4'b0011,
      ST_CMD_ACK  = 4'b0100,
      ST_WDATA    = 4'b0101,
      ST_WD_ACK   = 4'b0110,
      ST_RDATA    = 4'b0111,
      ST_RD_ACK   = 4'b1000,
      ST_IGNORE   = 4'b1001
   } dpt_state_e;

endpackage

// ### include/dpt_line_if.sv
// line events passed from the edge detector to the protocol engine
interface dpt_line_if;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic sda;

   modport detect (output rise, output fall, output start, output stop,
                   output sda);
   modport proto  (input rise, input fall, input start, input stop,
                   input sda);
endinterface

// ### logic/dpt_line_detect.sv
// clock edge and start/stop detection on the serial lines
module dpt_line_detect (
   // clock and reset
   input  wire logic     clk_i,
   input  wire logic     rst_b_i,
   // serial lines
   input  wire logic     scl_i,
   input  wire logic     sda_i,
   // events
   dpt_line_if.detect    ln
);

   // =====================================================
   // previous line levels
   logic scl_q;
   logic sda_q;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   // =====================================================
   // events
   // data moves only while clock is low; a data edge with clock high
   // frames a transfer
   assign ln.rise  = scl_i & ~scl_q;
   assign ln.fall  = ~scl_i & scl_q;
   assign ln.start = scl_i & scl_q & sda_q & ~sda_i;
   assign ln.stop  = scl_i & scl_q & ~sda_q & sda_i;
   assign ln.sda   = sda_i;

endmodule

// ### logic/dpt_top.sv
// two-wire slave, wiper and preset registers of the potentiometer
module dpt_top #(
   // device type value is arbitrary
   parameter logic [3:0] DEVICE_TYPE = 4'h9,
   parameter int unsigned WIPER_W = dpt_pkg::WIPER_W,
   parameter int unsigned PRESET_N = dpt_pkg::PRESET_N
) (
   // clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   // serial bus (clock is input only)
   input  wire logic              scl_i,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_o,
   // straps
   input  wire logic [2:0]        slave_addr_pins_i,
   input  wire logic              wp_b_i,
   // tap select
   output logic [WIPER_W-1:0]     wiper_position_reg_o
);

   // =====================================================
   // elaboration checks
   if (WIPER_W != 10) begin : g_bad_width
      $error("wiper width must be 10");
   end
   if (PRESET_N != 4) begin : g_bad_count
      $error("preset count must be 4");
   end

   // =====================================================
   // line events
   dpt_line_if ln ();

   dpt_line_detect u_detect (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .ln      (ln)
   );

   // =====================================================
   // state
   dpt_pkg::dpt_state_e state;
   logic [2:0]          cnt;
   logic [7:0]          shreg;
   logic                acking;
   logic                dir_rd;
   logic [2:0]          op;
   logic [1:0]          sel;
   logic                byte_idx;
   logic [7:0]          wr_lo;
   logic [7:0]          tx;
   logic [9:0]          rd_val;
   logic [9:0]          wiper;
   logic                recall_pend;
   logic [9:0]          preset_mem [PRESET_N];
   logic [39:0]         preset_flat;

   logic [7:0] byte_in;
   logic       last_bit;
   logic       addr_match;
   logic [2:0] in_op;
   logic [1:0] in_sel;
   logic       cmd_ok;
   logic       is_xfr;
   logic       pre_we;
   logic [1:0] pre_idx;
   logic [9:0] pre_wd;
   logic       wip_we;
   logic [9:0] wip_wd;

   assign byte_in  = {shreg[6:0], ln.sda};
   assign last_bit = ln.rise && (cnt == dpt_pkg::LAST_BIT);
   assign addr_match =
      (byte_in[dpt_pkg::TYPE_HI:dpt_pkg::TYPE_LO] == DEVICE_TYPE) &&
      (byte_in[dpt_pkg::PINS_HI:dpt_pkg::PINS_LO] == slave_addr_pins_i);
   assign in_op  = byte_in[dpt_pkg::OP_HI:dpt_pkg::OP_LO];
   assign in_sel = byte_in[dpt_pkg::SEL_HI:dpt_pkg::SEL_LO];
   // legal opcodes depend on the direction bit
   assign cmd_ok = dir_rd ?
      (in_op == dpt_pkg::OP_READ_WIPER || in_op == dpt_pkg::OP_READ_PRESET ||
       in_op == dpt_pkg::OP_XFR_TO_WIPER) :
      (in_op == dpt_pkg::OP_WRITE_WIPER || in_op == dpt_pkg::OP_WRITE_PRESET ||
       in_op == dpt_pkg::OP_XFR_TO_PRESET);
   assign is_xfr = dir_rd ? (op == dpt_pkg::OP_XFR_TO_WIPER) :
                            (op == dpt_pkg::OP_XFR_TO_PRESET);

   // =====================================================
   // register write requests
   always_comb begin
      pre_we  = 1'b0;
      pre_idx = in_sel;
      pre_wd  = wiper;
      wip_we  = 1'b0;
      wip_wd  = preset_mem[in_sel];
      if (state == dpt_pkg::ST_CMD && last_bit && !ln.start && !ln.stop
          && cmd_ok) begin
         if (!dir_rd && in_op == dpt_pkg::OP_XFR_TO_PRESET) begin
            pre_we = wp_b_i;
         end
         if (dir_rd && in_op == dpt_pkg::OP_XFR_TO_WIPER) begin
            wip_we = 1'b1;
         end
      end
      if (state == dpt_pkg::ST_WDATA && last_bit && byte_idx
          && !ln.start && !ln.stop) begin
         pre_idx = sel;
         pre_wd  = {byte_in[1:0], wr_lo};
         wip_wd  = {byte_in[1:0], wr_lo};
         if (op == dpt_pkg::OP_WRITE_WIPER) begin
            wip_we = 1'b1;
         end
         if (op == dpt_pkg::OP_WRITE_PRESET) begin
            pre_we = wp_b_i;
         end
      end
   end

   // =====================================================
   // preset storage
   genvar gi;
   for (gi = 0; gi < PRESET_N; gi++) begin : g_preset
      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            preset_mem[gi] <= dpt_pkg::PRESET_RESET;
         end else if (pre_we && pre_idx == 2'(gi)) begin
            preset_mem[gi] <= pre_wd;
         end
      end
      assign preset_flat[gi*10 +: 10] = preset_mem[gi];
   end

   // =====================================================
   // wiper register with recall after reset
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         recall_pend <= 1'b1;
      end else begin
         recall_pend <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wiper <= 10'h000;
      end else if (recall_pend) begin
         wiper <= preset_mem[0];
      end else if (wip_we) begin
         wiper <= wip_wd;
      end
   end

   assign wiper_position_reg_o = wiper;

   // =====================================================
   // protocol engine
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state    <= dpt_pkg::ST_IDLE;
         cnt      <= 3'h0;
         shreg    <= 8'h00;
         acking   <= 1'b0;
         dir_rd   <= 1'b0;
         op       <= 3'h0;
         sel      <= 2'h0;
         byte_idx <= 1'b0;
         wr_lo    <= 8'h00;
         tx       <= 8'h00;
         rd_val   <= 10'h000;
         sda_oe_o <= 1'b0;
      end else if (ln.start) begin
         state    <= dpt_pkg::ST_ADDR;
         cnt      <= 3'h0;
         acking   <= 1'b0;
         sda_oe_o <= 1'b0;
      end else if (ln.stop) begin
         state    <= dpt_pkg::ST_IDLE;
         acking   <= 1'b0;
         sda_oe_o <= 1'b0;
      end else begin
         case (state)
            dpt_pkg::ST_ADDR: begin
               if (ln.rise) begin
                  shreg <= byte_in;
                  cnt   <= cnt + 3'h1;
                  if (last_bit) begin
                     dir_rd <= byte_in[dpt_pkg::DIR_BIT];
                     state  <= addr_match ? dpt_pkg::ST_ADDR_ACK :
                                            dpt_pkg::ST_IGNORE;
                  end
               end
            end
            dpt_pkg::ST_ADDR_ACK, dpt_pkg::ST_WD_ACK: begin
               if (ln.fall) begin
                  if (!acking) begin
                     sda_oe_o <= 1'b1;
                     acking   <= 1'b1;
                  end else begin
                     sda_oe_o <= 1'b0;
                     acking   <= 1'b0;
                     cnt      <= 3'h0;
                     if (state == dpt_pkg::ST_WD_ACK) begin
                        byte_idx <= ~byte_idx;
                     end
                     state <= (state == dpt_pkg::ST_ADDR_ACK) ?
                              dpt_pkg::ST_CMD : dpt_pkg::ST_WDATA;
                  end
               end
            end
            dpt_pkg::ST_CMD: begin
               if (ln.rise) begin
                  shreg <= byte_in;
                  cnt   <= cnt + 3'h1;
                  if (last_bit) begin
                     op     <= in_op;
                     sel    <= in_sel;
                     rd_val <= (in_op == dpt_pkg::OP_READ_WIPER) ?
                               wiper : preset_mem[in_sel];
                     state  <= cmd_ok ? dpt_pkg::ST_CMD_ACK :
                                        dpt_pkg::ST_IGNORE;
                  end
               end
            end
            dpt_pkg::ST_CMD_ACK: begin
               if (ln.fall) begin
                  if (!acking) begin
                     sda_oe_o <= 1'b1;
                     acking   <= 1'b1;
                  end else begin
                     acking   <= 1'b0;
                     cnt      <= 3'h0;
                     byte_idx <= 1'b0;
                     if (is_xfr) begin
                        sda_oe_o <= 1'b0;
                        state    <= dpt_pkg::ST_IGNORE;
                     end else if (dir_rd) begin
                        tx       <= rd_val[7:0];
                        sda_oe_o <= ~rd_val[7];
                        state    <= dpt_pkg::ST_RDATA;
                     end else begin
                        sda_oe_o <= 1'b0;
                        state    <= dpt_pkg::ST_WDATA;
                     end
                  end
               end
            end
            dpt_pkg::ST_WDATA: begin
               if (ln.rise) begin
                  shreg <= byte_in;
                  cnt   <= cnt + 3'h1;
                  if (last_bit) begin
                     if (!byte_idx) begin
                        wr_lo <= byte_in;
                     end
                     state <= dpt_pkg::ST_WD_ACK;
                  end
               end
            end
            dpt_pkg::ST_RDATA: begin
               if (ln.rise) begin
                  cnt <= cnt + 3'h1;
                  if (last_bit) begin
                     state <= dpt_pkg::ST_RD_ACK;
                  end
               end else if (ln.fall) begin
                  tx       <= {tx[6:0], 1'b0};
                  sda_oe_o <= ~tx[6];
               end
            end
            dpt_pkg::ST_RD_ACK: begin
               if (ln.fall && !acking) begin
                  sda_oe_o <= 1'b0;
                  acking   <= 1'b1;
               end else if (ln.rise && acking) begin
                  if (ln.sda) begin
                     acking <= 1'b0;
                     state  <= dpt_pkg::ST_IGNORE;
                  end else begin
                     cnt <= 3'h1;
                  end
               end else if (ln.fall && acking && cnt == 3'h1) begin
                  byte_idx <= ~byte_idx;
                  tx       <= byte_idx ? rd_val[7:0] : {6'h00, rd_val[9:8]};
                  sda_oe_o <= byte_idx ? ~rd_val[7] : 1'b1;
                  acking   <= 1'b0;
                  cnt      <= 3'h0;
                  state    <= dpt_pkg::ST_RDATA;
               end
            end
            default: begin
               state <= state;
            end
         endcase
      end
   end

   // data output only ever pulls low; no clock output exists
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_addr_hit;
      state == dpt_pkg::ST_ADDR && last_bit && !ln.start && !ln.stop;
   endsequence
   sequence s_ack_begin;
      (state == dpt_pkg::ST_ADDR_ACK || state == dpt_pkg::ST_CMD_ACK ||
       state == dpt_pkg::ST_WD_ACK) && ln.fall && !acking &&
      !ln.start && !ln.stop;
   endsequence

   property p_recall;
      recall_pend |=> wiper == $past(preset_mem[0]);
   endproperty
   a_recall: assert property (p_recall)
      else $error("wiper not loaded from default preset");

   property p_open_drain;
      sda_o == 1'b0;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("data line driven high");

   property p_out_on_fall;
      $changed(sda_oe_o) |-> $past(ln.fall || ln.start || ln.stop);
   endproperty
   a_out_on_fall: assert property (p_out_on_fall)
      else $error("data output changed away from falling clock");

   property p_sample_rise;
      (state == dpt_pkg::ST_CMD && ln.rise && !ln.start && !ln.stop)
         |=> shreg[0] == $past(ln.sda);
   endproperty
   a_sample_rise: assert property (p_sample_rise)
      else $error("bit not sampled on rising clock");

   property p_mismatch;
      s_addr_hit ##0 !addr_match |=> state == dpt_pkg::ST_IGNORE;
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("mismatched address not ignored");

   property p_match;
      s_addr_hit ##0 addr_match |=> state == dpt_pkg::ST_ADDR_ACK;
   endproperty
   a_match: assert property (p_match)
      else $error("matching address not taken");

   property p_ack;
      s_ack_begin |=> sda_oe_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("acknowledge not driven");

   property p_ignore_quiet;
      state == dpt_pkg::ST_IGNORE && !recall_pend |=> !sda_oe_o &&
         $stable(wiper) && $stable(preset_flat);
   endproperty
   a_ignore_quiet: assert property (p_ignore_quiet)
      else $error("activity while ignoring bus");

   property p_protect;
      !wp_b_i |=> $stable(preset_flat);
   endproperty
   a_protect: assert property (p_protect)
      else $error("preset written while protected");

   property p_xfr_wiper;
      (wip_we && state == dpt_pkg::ST_CMD && !recall_pend)
         |=> wiper == $past(preset_mem[in_sel]);
   endproperty
   a_xfr_wiper: assert property (p_xfr_wiper)
      else $error("transfer to wiper lost");

endmodule

// ### testbench/dpt_master.sv
// two-wire bus master model that drives the serial clock and pulls data low
module dpt_master (
   // clock
   input  wire logic clk_i,
   // serial bus
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // =====================================================
   // idle bus: clock high, data released
   initial begin
      scl_o    = 1'b1;
      sda_oe_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // =====================================================
   // one bit: data moves only while the clock is low
   task automatic bit_io(input logic drv, output logic got);
      tick(1);
      sda_oe_o <= drv;
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      got = sda_i;
      scl_o <= 1'b0;
   endtask

   task automatic start();
      tick(1);
      sda_oe_o <= 1'b1;
      tick(2);
      scl_o <= 1'b0;
   endtask

   task automatic stop();
      tick(1);
      sda_oe_o <= 1'b1;
      tick(2);
      scl_o <= 1'b1;
      tick(2);
      sda_oe_o <= 1'b0;
      tick(2);
   endtask

   // =====================================================
   // byte transfers, most significant bit first
   task automatic wbyte(input logic [7:0] b, output logic acked);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(~b[i], g);
      end
      bit_io(1'b0, g);
      acked = ~g;
   endtask

   task automatic rbyte(input logic ack, output logic [7:0] b);
      logic g;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b0, g);
         b[i] = g;
      end
      bit_io(ack, g);
   endtask
endmodule

// ### testbench/dpt_top_test.sv
// self-checking bench of the potentiometer serial slave
module dpt_top_test;
   timeunit 1ns;
   timeprecision 1ps;

   // =====================================================
   // signals
   localparam logic [3:0] DEV_TYPE = 4'h9; // arbitrary device type value
   localparam int         LIMIT    = 20000;
   typedef struct packed {
      logic [2:0] wop;
      logic [2:0] rop;
      logic [1:0] sel;
      logic [9:0] v;
      logic [9:0] exp;
   } dpt_row_s;
   logic       clk_i;
   logic       rst_b_i;
   logic       scl;
   logic       m_oe;
   logic       sda_w;
   logic       sda_o;
   logic       sda_oe;
   logic [2:0] pins;
   logic       wp_b;
   logic [9:0] wiper;
   logic       oe_q      = 1'b0;
   int         err_count = 0;
   int         cmp_count = 0;
   int         cycles    = 0;
   dpt_row_s   rows [5];
   logic [3:0] acks;
   logic [9:0] got;

   // pull-up: line is low only while someone pulls it
   assign sda_w = ~((sda_oe & ~sda_o) | m_oe);

   dpt_top #(.DEVICE_TYPE(DEV_TYPE)) dpt_top_inst (
      .clk_i                (clk_i),
      .rst_b_i              (rst_b_i),
      .scl_i                (scl),
      .sda_i                (sda_w),
      .sda_o                (sda_o),
      .sda_oe_o             (sda_oe),
      .slave_addr_pins_i    (pins),
      .wp_b_i               (wp_b),
      .wiper_position_reg_o (wiper)
   );

   dpt_master dpt_master_inst (
      .clk_i    (clk_i),
      .sda_i    (sda_w),
      .scl_o    (scl),
      .sda_oe_o (m_oe)
   );

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // =====================================================
   // compares and closing
   task automatic chk_val(input logic [9:0] g, input logic [9:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_ack(input logic [3:0] g, input logic [3:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected acks at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_count++;
         close_out();
      end
   end

   // data output may only move while the serial clock is low
   always @(posedge clk_i) begin
      oe_q <= sda_oe;
      if (rst_b_i && oe_q !== sda_oe) begin
         chk_ack({3'h0, scl}, 4'h0);
         chk_ack({3'h0, sda_o}, 4'h0);
      end
   end

   // =====================================================
   // bus transactions
   function automatic logic [7:0] mk_adr(input logic dir);
      return {DEV_TYPE, pins, dir};
   endfunction

   function automatic logic [7:0] mk_cmd(input logic [2:0] op,
                                         input logic [1:0] sel);
      return {op, 1'b0, sel, 2'b00};
   endfunction

   task automatic wr(input logic [7:0] adr, input logic [7:0] c,
                     input logic [9:0] v, input bit data,
                     output logic [3:0] a);
      a = 4'h0;
      dpt_master_inst.start();
      dpt_master_inst.wbyte(adr, a[3]);
      dpt_master_inst.wbyte(c, a[2]);
      if (data) begin
         dpt_master_inst.wbyte(v[7:0], a[1]);
         dpt_master_inst.wbyte({6'h00, v[9:8]}, a[0]);
      end
      dpt_master_inst.stop();
   endtask

   task automatic rd(input logic [7:0] c, output logic [9:0] v,
                     output logic [3:0] a);
      logic [7:0] lo;
      logic [7:0] hi;
      a = 4'h0;
      dpt_master_inst.start();
      dpt_master_inst.wbyte(mk_adr(1'b1), a[3]);
      dpt_master_inst.wbyte(c, a[2]);
      dpt_master_inst.rbyte(1'b1, lo);
      dpt_master_inst.rbyte(1'b0, hi);
      dpt_master_inst.stop();
      v = {hi[1:0], lo};
   endtask

   // =====================================================
   // main sequence
   initial begin
      rst_b_i = 1'b0;
      pins    = 3'h5;
      wp_b    = 1'b1;
      rows    = '{
         '{dpt_pkg::OP_WRITE_WIPER, dpt_pkg::OP_READ_WIPER, 2'h0,
           10'h155, 10'h155},
         '{dpt_pkg::OP_WRITE_PRESET, dpt_pkg::OP_READ_PRESET, 2'h0,
           10'h3ff, 10'h3ff},
         '{dpt_pkg::OP_WRITE_PRESET, dpt_pkg::OP_READ_PRESET, 2'h1,
           10'h000, 10'h000},
         '{dpt_pkg::OP_WRITE_PRESET, dpt_pkg::OP_READ_PRESET, 2'h2,
           10'h2aa, 10'h2aa},
         '{dpt_pkg::OP_WRITE_PRESET, dpt_pkg::OP_READ_PRESET, 2'h3,
           10'h0c3, 10'h0c3}};
      repeat (3) @(posedge clk_i);
      chk_ack({3'h0, sda_oe}, 4'h0);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk_val(wiper, dpt_pkg::PRESET_RESET);
      foreach (rows[i]) begin
         wr(mk_adr(1'b0), mk_cmd(rows[i].wop, rows[i].sel), rows[i].v,
            1'b1, acks);
         chk_ack(acks, 4'hf);
         rd(mk_cmd(rows[i].rop, rows[i].sel), got, acks);
         chk_ack(acks, 4'hc);
         chk_val(got, rows[i].exp);
      end
      chk_val(wiper, 10'h155);
      // transfers in both directions
      wr(mk_adr(1'b1), mk_cmd(dpt_pkg::OP_XFR_TO_WIPER, 2'h2), 10'h0, 0, acks);
      chk_ack(acks, 4'hc);
      chk_val(wiper, 10'h2aa);
      wr(mk_adr(1'b0), mk_cmd(dpt_pkg::OP_WRITE_WIPER, 2'h0), 10'h011, 1, acks);
      wr(mk_adr(1'b0), mk_cmd(dpt_pkg::OP_XFR_TO_PRESET, 2'h1), 10'h0, 0, acks);
      rd(mk_cmd(dpt_pkg::OP_READ_PRESET, 2'h1), got, acks);
      chk_val(got, 10'h011);
      // write protect blocks stores but still acknowledges
      @(posedge clk_i);
      wp_b <= 1'b0;
      wr(mk_adr(1'b0), mk_cmd(dpt_pkg::OP_WRITE_PRESET, 2'h3), 10'h123, 1, acks);
      chk_ack(acks, 4'hf);
      wr(mk_adr(1'b0), mk_cmd(dpt_pkg::OP_XFR_TO_PRESET, 2'h3), 10'h0, 0, acks);
      rd(mk_cmd(dpt_pkg::OP_READ_PRESET, 2'h3), got, acks);
      chk_val(got, 10'h0c3);
      wp_b <= 1'b1;
      // foreign pins, foreign type, wrong direction, unknown opcode
      wr({DEV_TYPE, pins ^ 3'h1, 1'b0},
         mk_cmd(dpt_pkg::OP_WRITE_WIPER, 2'h0), 10'h3c3, 1, acks);
      chk_ack(acks, 4'h0);
      wr({~DEV_TYPE, pins, 1'b0},
         mk_cmd(dpt_pkg::OP_WRITE_WIPER, 2'h0), 10'h3c3, 1, acks);
      chk_ack(acks, 4'h0);
      chk_val(wiper, 10'h011);
      wr(mk_adr(1'b0), mk_cmd(dpt_pkg::OP_READ_WIPER, 2'h0), 10'h3c3, 1, acks);
      chk_ack(acks, 4'h8);
      wr(mk_adr(1'b0), mk_cmd(3'h0, 2'h0), 10'h3c3, 1, acks);
      chk_ack(acks, 4'h8);
      chk_val(wiper, 10'h011);
      // another strap setting
      @(posedge clk_i);
      pins <= 3'h2;
      wr({DEV_TYPE, 3'h5, 1'b0},
         mk_cmd(dpt_pkg::OP_WRITE_WIPER, 2'h0), 10'h3c3, 1, acks);
      chk_ack(acks, 4'h0);
      rd(mk_cmd(dpt_pkg::OP_READ_WIPER, 2'h0), got, acks);
      chk_ack(acks, 4'hc);
      chk_val(got, 10'h011);
      // reset in mid-run reloads the presets with PRESET_RESET and recalls into the wiper
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      chk_val(wiper, 10'h000);
      rst_b_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk_val(wiper, dpt_pkg::PRESET_RESET);
      rd(mk_cmd(dpt_pkg::OP_READ_WIPER, 2'h0), got, acks);
      chk_ack(acks, 4'hc);
      chk_val(got, dpt_pkg::PRESET_RESET);
      close_out();
   end
endmodule
